// [include/mid_pkg.sv]
package mid_pkg;
  // Word and datapath widths
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;

  // Instruction classes (top two bits)
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;

  // Byte-class sub-codes
  localparam logic [3:0] OP_SPECIAL = 4'h0;
  localparam logic [3:0] OP_CLR     = 4'h1;
  localparam logic [3:0] OP_SUB     = 4'h2;
  localparam logic [3:0] OP_DEC     = 4'h3;
  localparam logic [3:0] OP_IOR     = 4'h4;
  localparam logic [3:0] OP_AND     = 4'h5;
  localparam logic [3:0] OP_XOR     = 4'h6;
  localparam logic [3:0] OP_ADD     = 4'h7;
  localparam logic [3:0] OP_MOV     = 4'h8;
  localparam logic [3:0] OP_COM     = 4'h9;
  localparam logic [3:0] OP_INC     = 4'hA;
  localparam logic [3:0] OP_DECSZ   = 4'hB;
  localparam logic [3:0] OP_RRF     = 4'hC;
  localparam logic [3:0] OP_RLF     = 4'hD;
  localparam logic [3:0] OP_SWAP    = 4'hE;
  localparam logic [3:0] OP_INCSZ   = 4'hF;

  // Bit-class sub-codes (bits 11:10)
  localparam logic [1:0] BOP_CLR  = 2'h0;
  localparam logic [1:0] BOP_SET  = 2'h1;
  localparam logic [1:0] BOP_TSTC = 2'h2;
  localparam logic [1:0] BOP_TSTS = 2'h3;

  // Literal-class sub-codes and prefixes
  localparam logic [3:0] LOP_IOR   = 4'h8;
  localparam logic [3:0] LOP_AND   = 4'h9;
  localparam logic [3:0] LOP_XOR   = 4'hA;
  localparam logic [3:0] LOP_RSVD  = 4'hB;
  localparam logic [1:0] LOP_MOV_P = 2'h0;
  localparam logic [1:0] LOP_RET_P = 2'h1;
  localparam logic [2:0] LOP_SUB_P = 3'h6;
  localparam logic [2:0] LOP_ADD_P = 3'h7;

  // Fixed special words
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] W_SLEEP  = 14'h0063;
  localparam logic [13:0] W_WATCHDOG_CLEAR = 14'h0064;

  // Reset values and steps
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_STEP  = 13'h0001;
  localparam logic [12:0] PC_SKIP  = 13'h0002;
  localparam logic [7:0]  W_RESET  = 8'h00;
  localparam logic        TO_RESET = 1'b1;
  localparam logic        PD_RESET = 1'b1;

  // Four core clocks form one instruction cycle
  typedef enum logic [1:0] {
    Q_ADDR  = 2'b00,
    Q_FETCH = 2'b01,
    Q_READ  = 2'b10,
    Q_EXEC  = 2'b11
  } mid_quarter_e;
endpackage

// [rtl/mid_core.sv]
`timescale 1ns/1ps
`default_nettype none
module mid_core #(
  parameter logic [6:0] PORT_ADDR  = 7'h06,
  parameter logic [6:0] TIMER_ADDR = 7'h01
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [13:0] instrWord,
  output logic      [12:0] programAddr,
  input  wire logic [1:0]  pageSelect,
  input  wire logic [12:0] stackTop,
  output logic             stackPush,
  output logic             stackPop,
  output logic      [12:0] pushAddr,
  output logic      [6:0]  fileAddr,
  output logic             fileRdEn,
  input  wire logic [7:0]  fileRdData,
  output logic             fileWrEn,
  output logic      [7:0]  fileWrData,
  input  wire logic [7:0]  portPins,
  input  wire logic        prescalerToTimer,
  output logic             prescalerClear,
  input  wire logic        wakeUp,
  output logic             sleepMode,
  output logic             watchdogClear,
  output logic             interruptEnableSet,
  output logic      [7:0]  workReg,
  output logic             carryFlag,
  output logic             halfCarryFlag,
  output logic             zeroFlag,
  output logic             watchdogExpiryFlag,
  output logic             sleepStateFlag,
  output logic             secondCycle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  mid_pkg::mid_quarter_e quarter;
  mid_pkg::mid_quarter_e next_quarter;
  logic [13:0] instr;
  logic [7:0]  operand;
  logic [7:0]  portSync1;
  logic [7:0]  portSync2;
  logic [7:0]  portSync3;
  logic [7:0]  portStable;

  // Quarter sequencer: address, fetch, read, execute
  always_comb begin
    unique case (quarter)
      mid_pkg::Q_ADDR:  next_quarter = mid_pkg::Q_FETCH;
      mid_pkg::Q_FETCH: next_quarter = mid_pkg::Q_READ;
      mid_pkg::Q_READ:  next_quarter = mid_pkg::Q_EXEC;
      mid_pkg::Q_EXEC:  next_quarter = mid_pkg::Q_ADDR;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) quarter <= mid_pkg::Q_ADDR;
    else quarter <= next_quarter;
  end

  cycle_len_a: assert property ((quarter == mid_pkg::Q_EXEC) |-> ##4 (quarter == mid_pkg::Q_EXEC))
    else $error("instruction cycle not four clocks");

  // Field decode of the latched word
  wire [1:0] cls   = instr[13:12];
  wire [3:0] sub4  = instr[11:8];
  wire       dbit  = instr[7];
  wire [2:0] bsel  = instr[9:7];
  wire [7:0] lit   = instr[7:0];
  wire       isByte = (cls == mid_pkg::CLS_BYTE);
  wire       isBit  = (cls == mid_pkg::CLS_BIT);
  wire       isJump = (cls == mid_pkg::CLS_JUMP);
  wire       isLit  = (cls == mid_pkg::CLS_LIT);
  wire       isCall = isJump && !instr[11];
  wire       isSleep  = (instr == mid_pkg::W_SLEEP);
  wire       isClrWdt = (instr == mid_pkg::W_WATCHDOG_CLEAR);
  wire       isRetfie = (instr == mid_pkg::W_INTERRUPT_RETURN);
  wire       isRetLit = isLit && (sub4[3:2] == mid_pkg::LOP_RET_P);
  wire       retAny   = isRetLit || isRetfie || (instr == mid_pkg::W_RETURN);
  wire [1:0] bitOp    = instr[11:10];

  // Adder shared by add and subtract forms; subtract adds ~W plus one
  wire       isSubOp = (isByte && sub4 == mid_pkg::OP_SUB)
                    || (isLit && sub4[3:1] == mid_pkg::LOP_SUB_P);
  wire       isAddOp = (isByte && sub4 == mid_pkg::OP_ADD)
                    || (isLit && sub4[3:1] == mid_pkg::LOP_ADD_P);
  wire [7:0] aluA = isLit ? lit : operand;
  wire [7:0] aluB = isSubOp ? ~workReg : workReg;
  wire [8:0] sum9 = {1'b0, aluA} + {1'b0, aluB} + {8'h00, isSubOp};
  wire [4:0] half5 = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, isSubOp};

  // Byte-class results
  wire [7:0] byteRes =
    (sub4 == mid_pkg::OP_SPECIAL) ? workReg :
    (sub4 == mid_pkg::OP_CLR)     ? 8'h00 :
    (sub4 == mid_pkg::OP_SUB || sub4 == mid_pkg::OP_ADD) ? sum9[7:0] :
    (sub4 == mid_pkg::OP_DEC || sub4 == mid_pkg::OP_DECSZ) ? operand - 8'h01 :
    (sub4 == mid_pkg::OP_IOR)     ? (workReg | operand) :
    (sub4 == mid_pkg::OP_AND)     ? (workReg & operand) :
    (sub4 == mid_pkg::OP_XOR)     ? (workReg ^ operand) :
    (sub4 == mid_pkg::OP_MOV)     ? operand :
    (sub4 == mid_pkg::OP_COM)     ? ~operand :
    (sub4 == mid_pkg::OP_RRF)     ? {carryFlag, operand[7:1]} :
    (sub4 == mid_pkg::OP_RLF)     ? {operand[6:0], carryFlag} :
    (sub4 == mid_pkg::OP_SWAP)    ? {operand[3:0], operand[7:4]} :
    operand + 8'h01;

  // Bit-class results
  wire [7:0] bitMask = 8'h01 << bsel;
  wire       testedBit = operand[bsel];
  wire [7:0] bitRes = (bitOp == mid_pkg::BOP_SET) ? (operand | bitMask) : (operand & ~bitMask);

  // Literal-class results
  wire [7:0] litRes =
    (sub4 == mid_pkg::LOP_IOR) ? (workReg | lit) :
    (sub4 == mid_pkg::LOP_AND) ? (workReg & lit) :
    (sub4 == mid_pkg::LOP_XOR) ? (workReg ^ lit) :
    (sub4[3] == 1'b1) ? sum9[7:0] : lit;

  wire [7:0] result  = isLit ? litRes : (isBit ? bitRes : byteRes);
  wire       resZero = (result == 8'h00);

  // Destination and flag selection
  wire writeW = (isByte && !dbit && sub4 != mid_pkg::OP_SPECIAL)
             || (isLit && sub4 != mid_pkg::LOP_RSVD);
  wire writeFile = (isByte && dbit) || (isBit && !instr[11]);
  wire updZ = (isByte && !(sub4 inside {mid_pkg::OP_SPECIAL, mid_pkg::OP_DECSZ,
              mid_pkg::OP_INCSZ, mid_pkg::OP_RRF, mid_pkg::OP_RLF, mid_pkg::OP_SWAP}))
           || (isLit && sub4[3] && sub4 != mid_pkg::LOP_RSVD);
  wire updArith = isSubOp || isAddOp;
  wire updRot = isByte && (sub4 == mid_pkg::OP_RRF || sub4 == mid_pkg::OP_RLF);
  wire rotCarry = (sub4 == mid_pkg::OP_RLF) ? operand[7] : operand[0];

  // Conditional skips and program-counter changes
  wire skipTaken = (isByte && (sub4 == mid_pkg::OP_DECSZ || sub4 == mid_pkg::OP_INCSZ) && resZero)
                || (isBit && bitOp == mid_pkg::BOP_TSTC && !testedBit)
                || (isBit && bitOp == mid_pkg::BOP_TSTS && testedBit);
  wire pcChange = isJump || retAny;
  wire twoCycle = pcChange || skipTaken;
  wire [12:0] pcPlus = programAddr + (skipTaken ? mid_pkg::PC_SKIP : mid_pkg::PC_STEP);
  wire [12:0] next_pc = isJump ? {pageSelect, instr[10:0]} :
                        (retAny ? stackTop : pcPlus);
  wire execNow = (quarter == mid_pkg::Q_EXEC) && !secondCycle && !sleepMode;
  wire tmrClear = execNow && writeFile && instr[6:0] == TIMER_ADDR && prescalerToTimer;

  // Fetched word names a file register; reads happen even for pure writes
  wire fetchNames = (instrWord[13:12] == mid_pkg::CLS_BIT)
                 || (instrWord[13:12] == mid_pkg::CLS_BYTE && instrWord[11:7] != 5'h00);
  wire [7:0] readSource = (fileAddr == PORT_ADDR) ? portStable : fileRdData;

  // Pin synchroniser; a bit moves only when stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      portSync1  <= 8'h00;
      portSync2  <= 8'h00;
      portSync3  <= 8'h00;
      portStable <= 8'h00;
    end else begin
      portSync1  <= portPins;
      portSync2  <= portSync1;
      portSync3  <= portSync2;
      portStable <= (portSync2 & portSync3) | (portStable & (portSync2 | portSync3));
    end
  end

  // Fetch and operand read; a NOP cycle issues no read, avoiding side effects
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr    <= 14'h0000;
      fileAddr <= 7'h00;
      fileRdEn <= 1'b0;
      operand  <= 8'h00;
    end else begin
      fileRdEn <= 1'b0;
      if (quarter == mid_pkg::Q_FETCH) begin
        instr    <= instrWord;
        fileAddr <= instrWord[6:0];
        fileRdEn <= fetchNames && !secondCycle && !sleepMode;
      end
      if (quarter == mid_pkg::Q_READ) operand <= readSource;
    end
  end

  // Working register, flags and program counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      workReg       <= mid_pkg::W_RESET;
      carryFlag     <= 1'b0;
      halfCarryFlag <= 1'b0;
      zeroFlag      <= 1'b0;
      programAddr   <= mid_pkg::PC_RESET;
    end else if (execNow) begin
      if (writeW) workReg <= result;
      if (updZ) zeroFlag <= resZero;
      if (updArith) begin
        carryFlag     <= sum9[8];
        halfCarryFlag <= half5[4];
      end
      if (updRot) carryFlag <= rotCarry;
      programAddr <= next_pc;
    end
  end

  // Cycle stretch, power state and one-clock strobes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      secondCycle        <= 1'b0;
      sleepMode          <= 1'b0;
      watchdogExpiryFlag <= mid_pkg::TO_RESET;
      sleepStateFlag     <= mid_pkg::PD_RESET;
      fileWrEn           <= 1'b0;
      fileWrData         <= 8'h00;
      stackPush          <= 1'b0;
      stackPop           <= 1'b0;
      pushAddr           <= mid_pkg::PC_RESET;
      prescalerClear     <= 1'b0;
      watchdogClear      <= 1'b0;
      interruptEnableSet <= 1'b0;
    end else begin
      fileWrEn           <= execNow && writeFile;
      stackPush          <= execNow && isCall;
      stackPop           <= execNow && retAny;
      prescalerClear     <= tmrClear;
      watchdogClear      <= execNow && (isSleep || isClrWdt);
      interruptEnableSet <= execNow && isRetfie;
      if (execNow) begin
        fileWrData <= result;
        pushAddr   <= programAddr + mid_pkg::PC_STEP;
      end
      if (quarter == mid_pkg::Q_EXEC) secondCycle <= execNow && twoCycle;
      if (execNow && (isSleep || isClrWdt)) begin
        watchdogExpiryFlag <= 1'b1;
        sleepStateFlag     <= !isSleep;
      end
      if (execNow && isSleep) sleepMode <= 1'b1;
      else if (wakeUp) sleepMode <= 1'b0;
    end
  end

  // Checks on the executed instruction
  sequence sqExec(logic [3:0] code, logic [1:0] c);
    execNow && cls == c && sub4 == code;
  endsequence

  or_file_a: assert property (sqExec(mid_pkg::OP_IOR, mid_pkg::CLS_BYTE)
    |=> zeroFlag == (fileWrData == 8'h00)) else $error("or with file zero flag wrong");
  xor_dest_a: assert property (sqExec(mid_pkg::OP_XOR, mid_pkg::CLS_BYTE) ##0 dbit
    |=> fileWrEn && fileWrData == ($past(workReg) ^ $past(operand)))
    else $error("xor with file not written to file");
  rot_carry_a: assert property (sqExec(mid_pkg::OP_RLF, mid_pkg::CLS_BYTE)
    |=> carryFlag == $past(operand[7]) && $stable(zeroFlag) && $stable(halfCarryFlag))
    else $error("rotate left carry wrong");
  dec_skip_a: assert property (sqExec(mid_pkg::OP_DECSZ, mid_pkg::CLS_BYTE) ##0 operand == 8'h01
    |=> secondCycle && $stable(zeroFlag) ##4 !secondCycle) else $error("decrement skip missed");
  inc_skip_a: assert property (sqExec(mid_pkg::OP_INCSZ, mid_pkg::CLS_BYTE) ##0 operand == 8'hFF
    |=> secondCycle && $stable(carryFlag)) else $error("increment skip missed");
  btest_clr_a: assert property (execNow && isBit && bitOp == mid_pkg::BOP_TSTC
    |=> secondCycle == !$past(testedBit)) else $error("bit test clear skip wrong");
  btest_set_a: assert property (execNow && isBit && bitOp == mid_pkg::BOP_TSTS
    |=> secondCycle == $past(testedBit) && $stable(zeroFlag)) else $error("bit test set wrong");
  lit_add_a: assert property (execNow && isAddOp && isLit
    |=> workReg == $past(lit) + $past(workReg)) else $error("add literal result wrong");
  lit_sub_a: assert property (execNow && isSubOp && isLit
    |=> workReg == $past(lit) - $past(workReg)) else $error("subtract from literal wrong");
  ret_lit_a: assert property (execNow && isRetLit
    |=> workReg == $past(lit) && programAddr == $past(stackTop) && secondCycle)
    else $error("return with literal wrong");
  standby_a: assert property (execNow && isSleep
    |=> sleepMode && watchdogExpiryFlag && !sleepStateFlag) else $error("standby entry wrong");
  port_pin_a: assert property ((quarter == mid_pkg::Q_READ) && fileAddr == PORT_ADDR
    |=> operand == $past(portStable)) else $error("port read not from pins");
  tmr_clear_a: assert property (tmrClear |=> prescalerClear)
    else $error("prescaler not cleared");
  nop_cycle_a: assert property (secondCycle && (quarter == mid_pkg::Q_EXEC)
    |=> !fileWrEn && $stable(workReg) && $stable(programAddr)) else $error("nop cycle acted");
  call_push_a: assert property (execNow && isCall
    |=> stackPush && pushAddr == $past(programAddr) + mid_pkg::PC_STEP && secondCycle)
    else $error("call did not push");
endmodule
`default_nettype wire

// [testbench/mid_prog_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// Program store that answers at once for the address it is shown
module mid_prog_mem (
  input  wire logic [12:0] addr,
  output logic      [13:0] word
);
  logic [13:0] mem [0:255];

  // Unloaded words decode as no-operation, so a stray fetch stays harmless
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 14'h0000;
    end
  end

  // Bench loads after time zero so it never races the clear above
  task automatic put(input logic [7:0] a, input logic [13:0] w);
    mem[a] = w;
  endtask

  // Only the low address byte is decoded; the image is small
  assign word = mem[addr[7:0]];
endmodule
`default_nettype wire

// [testbench/mcu_14bit_instruction_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mcu_14bit_instruction_decoder_tb;
  localparam int TIMEOUT = 1500;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        prescalerToTimer = 1'b1;
  logic        wakeUp = 1'b0;
  logic [1:0]  pageSelect = 2'h0;
  logic [7:0]  portPins = 8'h30;
  logic [7:0]  fileRdData = 8'h00;
  logic [12:0] stackTop = 13'h0000;
  logic [13:0] instrWord;
  logic [12:0] programAddr, pushAddr;
  logic [7:0]  workReg, fileWrData;
  logic [6:0]  fileAddr;
  logic        stackPush, stackPop, fileRdEn, fileWrEn, prescalerClear, sleepMode;
  logic        watchdogClear, interruptEnableSet, carryFlag, halfCarryFlag, zeroFlag;
  logic        watchdogExpiryFlag, sleepStateFlag, secondCycle;
  logic [7:0]  fm [0:127];
  int          failCount = 0;
  int          checked = 0;
  int          cyc = 0;
  int          rdCnt = 0;
  int          pushCnt = 0;
  int          popCnt = 0;
  int          wdcCnt = 0;
  int          preCnt = 0;
  int          ieCnt = 0;

  mid_prog_mem pm (.addr(programAddr), .word(instrWord));

  mid_core dut (
    .clk(clk), .arst_n(arst_n), .instrWord(instrWord), .programAddr(programAddr),
    .pageSelect(pageSelect), .stackTop(stackTop), .stackPush(stackPush),
    .stackPop(stackPop), .pushAddr(pushAddr), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
    .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
    .portPins(portPins), .prescalerToTimer(prescalerToTimer),
    .prescalerClear(prescalerClear), .wakeUp(wakeUp), .sleepMode(sleepMode),
    .watchdogClear(watchdogClear), .interruptEnableSet(interruptEnableSet),
    .workReg(workReg), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
    .zeroFlag(zeroFlag), .watchdogExpiryFlag(watchdogExpiryFlag),
    .sleepStateFlag(sleepStateFlag), .secondCycle(secondCycle)
  );

  // Core clock, 4 ns period
  always #2 clk = ~clk;

  // Strobe counters; a hang is cut short by the cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fileRdEn === 1'b1) rdCnt <= rdCnt + 1;
    if (stackPush === 1'b1) pushCnt <= pushCnt + 1;
    if (stackPop === 1'b1) popCnt <= popCnt + 1;
    if (watchdogClear === 1'b1) wdcCnt <= wdcCnt + 1;
    if (prescalerClear === 1'b1) preCnt <= preCnt + 1;
    if (interruptEnableSet === 1'b1) ieCnt <= ieCnt + 1;
    if (cyc >= TIMEOUT) begin
      failCount++;
      completeRun();
    end
  end

  // File store and return-address holder, updated off the sampling edge
  always @(negedge clk) begin
    if (fileWrEn === 1'b1) fm[fileAddr] <= fileWrData;
    if (stackPush === 1'b1) stackTop <= pushAddr;
    fileRdData <= fm[fileAddr];
  end

  function automatic logic [13:0] bw(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {mid_pkg::CLS_BYTE, op, d, f};
  endfunction

  function automatic logic [13:0] bt(input logic [1:0] op, input logic [2:0] b, input logic [6:0] f);
    return {mid_pkg::CLS_BIT, op, b, f};
  endfunction

  function automatic logic [13:0] lw(input logic [3:0] op, input logic [7:0] k);
    return {mid_pkg::CLS_LIT, op, k};
  endfunction

  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Waits for the counter to reach an address; the clock count is the cost
  task automatic step(input logic [12:0] a, input int clocks);
    int n;
    n = 0;
    while (programAddr !== a && n < 40) begin
      @(negedge clk);
      n++;
    end
    checked++;
    if (n != clocks) begin
      failCount++;
      $display("MISMATCH t=%0t address %0h after %0d clocks", $time, a, n);
    end
  endtask

  task automatic st(input logic [12:0] a, input int n, input logic [7:0] w, input logic [2:0] f);
    step(a, n);
    chk({5'h00, workReg}, {5'h00, w}, "work register");
    chk({10'h000, carryFlag, halfCarryFlag, zeroFlag}, {10'h000, f}, "flags C DC Z");
  endtask

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Skipped slots load 0xEE so a missed skip shows in the work register
  initial begin
    #1;
    for (int i = 0; i < 128; i++) begin
      fm[i] = 8'h00;
    end
    fm[7'h21] = 8'h81;
    fm[7'h22] = 8'h01;
    fm[7'h23] = 8'hFE;
    pm.put(8'h00, lw(4'h0, 8'h30));
    pm.put(8'h01, bw(4'h0, 1'b1, 7'h20));
    pm.put(8'h02, lw(mid_pkg::LOP_IOR, 8'h05));
    pm.put(8'h03, lw(mid_pkg::LOP_XOR, 8'h35));
    pm.put(8'h04, lw(4'h0, 8'h88));
    pm.put(8'h05, lw(4'hE, 8'h78));
    pm.put(8'h06, lw(4'h0, 8'h06));
    pm.put(8'h07, lw(4'hC, 8'h05));
    pm.put(8'h08, bw(4'h6, 1'b0, 7'h20));
    pm.put(8'h09, bw(4'h4, 1'b1, 7'h06));
    pm.put(8'h0A, bw(4'hD, 1'b1, 7'h21));
    pm.put(8'h0B, bw(4'hC, 1'b0, 7'h21));
    pm.put(8'h0C, bw(4'hB, 1'b1, 7'h22));
    pm.put(8'h0D, lw(4'h0, 8'hEE));
    pm.put(8'h0E, bw(4'hF, 1'b1, 7'h23));
    pm.put(8'h0F, bw(4'hF, 1'b0, 7'h23));
    pm.put(8'h10, lw(4'h0, 8'hEE));
    pm.put(8'h11, bt(2'h2, 3'h1, 7'h21));
    pm.put(8'h12, bt(2'h3, 3'h1, 7'h21));
    pm.put(8'h13, lw(4'h0, 8'hEE));
    pm.put(8'h14, bt(2'h2, 3'h0, 7'h21));
    pm.put(8'h15, lw(4'h0, 8'hEE));
    pm.put(8'h16, bw(4'h0, 1'b1, 7'h01));
    pm.put(8'h17, bw(4'h8, 1'b0, 7'h01));
    pm.put(8'h18, 14'h2030);
    pm.put(8'h19, mid_pkg::W_WATCHDOG_CLEAR);
    pm.put(8'h1A, mid_pkg::W_SLEEP);
    pm.put(8'h1B, mid_pkg::W_INTERRUPT_RETURN);
    pm.put(8'h30, lw(4'h4, 8'h5A));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    st(13'h0001, 4, 8'h30, 3'b000);
    st(13'h0002, 4, 8'h30, 3'b000);
    chk(rdCnt[12:0], 13'h0001, "read before store");
    st(13'h0003, 4, 8'h35, 3'b000);
    st(13'h0004, 4, 8'h00, 3'b001);
    st(13'h0005, 4, 8'h88, 3'b001);
    st(13'h0006, 4, 8'h00, 3'b111);
    st(13'h0007, 4, 8'h06, 3'b111);
    st(13'h0008, 4, 8'hFF, 3'b000);
    st(13'h0009, 4, 8'hCF, 3'b000);
    chk({5'h00, fm[7'h20]}, 13'h0030, "file kept on W destination");
    st(13'h000A, 4, 8'hCF, 3'b000);
    st(13'h000B, 4, 8'hCF, 3'b100);
    chk({5'h00, fm[7'h06]}, 13'h00FF, "port result from pins");
    st(13'h000C, 4, 8'h81, 3'b000);
    chk({5'h00, fm[7'h21]}, 13'h0002, "rotated file");
    st(13'h000E, 4, 8'h81, 3'b000);
    chk({12'h000, secondCycle}, 13'h0001, "idle cycle after skip");
    st(13'h000F, 8, 8'h81, 3'b000);
    chk({5'h00, fm[7'h22]}, 13'h0000, "decremented file");
    st(13'h0011, 4, 8'h00, 3'b000);
    st(13'h0012, 8, 8'h00, 3'b000);
    chk({5'h00, fm[7'h23]}, 13'h00FF, "incremented file");
    st(13'h0014, 4, 8'h00, 3'b000);
    st(13'h0016, 8, 8'h00, 3'b000);
    st(13'h0017, 8, 8'h00, 3'b000);
    st(13'h0018, 4, 8'h00, 3'b001);
    st(13'h0030, 4, 8'h00, 3'b001);
    chk(preCnt[12:0], 13'h0001, "prescaler clears");
    st(13'h0019, 8, 8'h5A, 3'b001);
    st(13'h001A, 8, 8'h5A, 3'b001);
    chk({pushCnt[5:0], popCnt[6:0]}, 13'h0081, "push and pop counts");
    st(13'h001B, 4, 8'h5A, 3'b001);
    repeat (2) @(negedge clk);
    chk({12'h000, sleepMode}, 13'h0001, "standby entered");
    chk({11'h000, watchdogExpiryFlag, sleepStateFlag}, 13'h0002, "TO PD flags");
    chk(wdcCnt[12:0], 13'h0002, "watchdog clear strobes");
    wakeUp = 1'b1;
    @(negedge clk);
    wakeUp = 1'b0;
    chk({12'h000, sleepMode}, 13'h0000, "wake from standby");
    repeat (4) @(negedge clk);
    chk(ieCnt[12:0], 13'h0001, "interrupt return strobe");
    chk(programAddr, 13'h0019, "interrupt return address");
    completeRun();
  end
endmodule
`default_nettype wire
